// ===== rtl/fws_defines.vh
// constants for the flash write-status host controller
`ifndef FWS_DEFINES_VH
`define FWS_DEFINES_VH
`define FWS_OFS_CTRL 8'h00
`define FWS_OFS_ADDR 8'h04
`define FWS_OFS_DATA 8'h08
`define FWS_OFS_STAT 8'h0c
`define FWS_OFS_RDATA 8'h10
`define FWS_CTRL_GO 0
`define FWS_CTRL_MODE 1
`define FWS_CTRL_RST 2
`define FWS_STAT_BUSY 0
`define FWS_STAT_DONE 1
`define FWS_STAT_FAIL 2
`define FWS_STAT_RYBY 3
`define FWS_MODE_POLL 1'b0
`define FWS_MODE_TOGGLE 1'b1
`define FWS_STROBE_NS 200
`define FWS_CLK_NS 100
`define FWS_STROBE_CYC ((`FWS_STROBE_NS + `FWS_CLK_NS - 1) / `FWS_CLK_NS)
`define FWS_RESET_CMD 16'h00f0
`endif

// ===== rtl/fws_ahb_slave.v
// ahb-lite register slave for the status controller
`timescale 1ns/1ns
`include "fws_defines.vh"
module fws_ahb_slave (
  input wire clk,
  input wire rst_n,
  input wire ce,
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire [31:0] hwdata,
  input wire [31:0] stat,
  input wire [15:0] rdata,
  output reg [31:0] hrdata,
  output wire [2:0] ctrl,
  output wire ctrl_wr,
  output reg [15:0] addr_q,
  output reg [15:0] data_q
);
  reg wr_q;
  reg [7:0] wa_q;
  reg [2:0] ctrl_q;
  wire take = hsel & htrans[1] & hready;
  assign ctrl = ctrl_q;
  assign ctrl_wr = wr_q & (wa_q == `FWS_OFS_CTRL) & ce;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= 1'b0;
      wa_q <= 8'h00;
      ctrl_q <= 3'h0;
      addr_q <= 16'h0000;
      data_q <= 16'h0000;
      hrdata <= 32'h0000_0000;
    end else if (ce) begin
      if (take) begin
        wr_q <= hwrite;
        wa_q <= haddr;
      end else begin
        wr_q <= 1'b0;
      end
      if (wr_q) begin
        case (wa_q)
          `FWS_OFS_CTRL: ctrl_q <= hwdata[2:0];
          `FWS_OFS_ADDR: addr_q <= hwdata[15:0];
          `FWS_OFS_DATA: data_q <= hwdata[15:0];
          default: ;
        endcase
      end
      if (take && !hwrite) begin
        case (haddr)
          `FWS_OFS_CTRL: hrdata <= {29'h0, ctrl_q};
          `FWS_OFS_ADDR: hrdata <= {16'h0, addr_q};
          `FWS_OFS_DATA: hrdata <= {16'h0, data_q};
          `FWS_OFS_STAT: hrdata <= stat;
          `FWS_OFS_RDATA: hrdata <= {16'h0, rdata};
          default: hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule // fws_ahb_slave

// ===== rtl/fws_host.v
// host controller polling flash program/erase status
// Functional notes
// [R01] device shows inverted bit 7 while programming, true bit when done
// [R02] same polarity behaviour applies to programming during erase suspend
// [R03] protected program address: polling active about 1 us, then read mode
// [R04] erase drives poll bit low, high when done or suspended
// [R05] all erase sectors protected: polling active about 400 us
// [R06] partly protected erase skips protected sectors silently
// [R07] poll bit valid from final write strobe rising edge
// [R08] host polls the program address or an erasing sector address
// [R09] poll bit may be invalid at protected sector during erase
// [R10] host takes array data only from reads after completion shown
// [R11] chip erase: any unprotected address; sector erase: erasing sector
// [R12] ready/busy low while programming or erasing, high otherwise
// [R13] toggle bit inverts each read during an operation, then stops
// [R14] toggle bit readable at any address from final write strobe
// [R15] all erase sectors protected: toggle about 400 us then array data
// [R16] protected program address: toggle about 1 us then array data
// [R17] toggle stops in erase suspend, resumes for suspend-program
// [R18] host may pace status reads with output enable or chip select
// [R19] host rereads status once more after timeout flag seen high
// [R20] device sets timeout flag when pulse count limit exceeded
// [R21] after timeout host writes reset command to the bank
// [R22] sector toggle bit toggles on reads in erase-selected sectors
// [R23] toggle bits modelled as flip-flops inverting per status read
//
// Implementation choices: the AHB-Lite register port and the address map.
`timescale 1ns/1ns
`include "fws_defines.vh"
module fws_host #(
  parameter STROBE_CYC = `FWS_STROBE_CYC
) (
  input wire I_MCLK,
  input wire I_RSTN,
  input wire I_CE,
  input wire I_HSEL,
  input wire [7:0] I_HADDR,
  input wire [1:0] I_HTRANS,
  input wire I_HWRITE,
  input wire [2:0] I_HSIZE,
  input wire I_HREADY,
  input wire [31:0] I_HWDATA,
  output wire [31:0] O_HRDATA,
  output reg O_HREADYOUT,
  output reg O_HRESP,
  input wire [15:0] I_DATA_BUS_WORD,
  input wire I_READY_BUSY_N,
  output reg [15:0] O_DATA_BUS_WORD,
  output reg O_DATA_BUS_OE,
  output reg [15:0] O_FLASH_ADDR,
  output reg O_FLASH_CHIP_SELECT_N,
  output reg O_OUTPUT_ENABLE_N,
  output reg O_WRITE_STROBE_N
);
  localparam S_IDLE = 3'd0;
  localparam S_RD1 = 3'd1;
  localparam S_RD2 = 3'd2;
  localparam S_EVAL = 3'd3;
  localparam S_RST = 3'd4;
  localparam S_DATA = 3'd5;
  localparam P_IDLE = 2'd0;
  localparam P_LOW = 2'd1;
  localparam P_HIGH = 2'd2;
  reg [2:0] st_q;
  reg [1:0] ph_q;
  reg [3:0] cnt_q;
  reg cyc_wr_q;
  reg [15:0] first_q;
  reg [15:0] cur_q;
  reg [15:0] rdata_q;
  reg recheck_q;
  reg busy_q;
  reg done_q;
  reg fail_q;
  reg ryby_q;
  wire [2:0] ctrl;
  wire ctrl_wr;
  wire [15:0] addr_q;
  wire [15:0] data_q;
  wire [31:0] stat;
  wire cyc_end;
  wire toggling;
  wire polled_done;
  wire go;
  assign stat = {28'h0, ryby_q, fail_q, done_q, busy_q};
  assign go = ctrl_wr & I_HWDATA[`FWS_CTRL_GO];
  assign cyc_end = (ph_q == P_HIGH) && (cnt_q == 4'd0);
  // two successive reads differ while an operation runs
  assign toggling = first_q[6] != cur_q[6]; // [R13]
  assign polled_done = cur_q[7] == data_q[7]; // [R01]
  fws_ahb_slave u_slave (
    .clk(I_MCLK),
    .rst_n(I_RSTN),
    .ce(I_CE),
    .hsel(I_HSEL),
    .haddr(I_HADDR),
    .htrans(I_HTRANS),
    .hwrite(I_HWRITE),
    .hready(I_HREADY),
    .hwdata(I_HWDATA),
    .stat(stat),
    .rdata(rdata_q),
    .hrdata(O_HRDATA),
    .ctrl(ctrl),
    .ctrl_wr(ctrl_wr),
    .addr_q(addr_q),
    .data_q(data_q)
  );
  // one bus cycle: strobe low for STROBE_CYC, high for STROBE_CYC
  always @(posedge I_MCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      ph_q <= P_IDLE;
      cnt_q <= 4'd0;
      O_FLASH_CHIP_SELECT_N <= 1'b1;
      O_OUTPUT_ENABLE_N <= 1'b1;
      O_WRITE_STROBE_N <= 1'b1;
      O_DATA_BUS_OE <= 1'b0;
      cur_q <= 16'h0000;
    end else if (I_CE) begin
      case (ph_q)
        P_IDLE: begin
          if ((st_q == S_RD1 || st_q == S_RD2 || st_q == S_RST ||
               st_q == S_DATA) && !cyc_wr_q) begin
            ph_q <= P_LOW;
            cnt_q <= STROBE_CYC[3:0] - 4'd1;
            O_FLASH_CHIP_SELECT_N <= 1'b0;
            // reads paced by output enable, chip select pulsed with it
            O_OUTPUT_ENABLE_N <= (st_q == S_RST); // [R18]
            O_WRITE_STROBE_N <= (st_q != S_RST);
            O_DATA_BUS_OE <= (st_q == S_RST);
          end
        end
        P_LOW: begin
          if (cnt_q != 4'd0) begin
            cnt_q <= cnt_q - 4'd1;
          end else begin
            cur_q <= I_DATA_BUS_WORD;
            ph_q <= P_HIGH;
            cnt_q <= STROBE_CYC[3:0] - 4'd1;
            O_FLASH_CHIP_SELECT_N <= 1'b1;
            O_OUTPUT_ENABLE_N <= 1'b1;
            O_WRITE_STROBE_N <= 1'b1;
          end
        end
        P_HIGH: begin
          O_DATA_BUS_OE <= 1'b0;
          if (cnt_q != 4'd0) begin
            cnt_q <= cnt_q - 4'd1;
          end else begin
            ph_q <= P_IDLE;
          end
        end
        default: ph_q <= P_IDLE;
      endcase
    end
  end
  // status polling sequence
  always @(posedge I_MCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      st_q <= S_IDLE;
      cyc_wr_q <= 1'b0;
      first_q <= 16'h0000;
      rdata_q <= 16'h0000;
      recheck_q <= 1'b0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      fail_q <= 1'b0;
      ryby_q <= 1'b0;
      O_DATA_BUS_WORD <= 16'h0000;
      O_FLASH_ADDR <= 16'h0000;
      O_HREADYOUT <= 1'b1;
      O_HRESP <= 1'b0;
    end else if (I_CE) begin
      ryby_q <= I_READY_BUSY_N; // [R12]
      cyc_wr_q <= 1'b0;
      case (st_q)
        S_IDLE: begin
          if (go) begin
            // status address must be the program or erasing address
            O_FLASH_ADDR <= addr_q; // [R08] [R11]
            busy_q <= 1'b1;
            done_q <= 1'b0;
            fail_q <= 1'b0;
            recheck_q <= 1'b0;
            st_q <= S_RD1;
          end else if (ctrl_wr && I_HWDATA[`FWS_CTRL_RST]) begin
            O_DATA_BUS_WORD <= `FWS_RESET_CMD;
            busy_q <= 1'b1;
            st_q <= S_RST;
          end
        end
        S_RD1: begin
          if (cyc_end) begin
            first_q <= cur_q;
            cyc_wr_q <= 1'b1;
            st_q <= S_RD2;
          end
        end
        S_RD2: begin
          if (cyc_end) begin
            cyc_wr_q <= 1'b1;
            st_q <= S_EVAL;
          end
        end
        S_EVAL: begin
          if ((ctrl[`FWS_CTRL_MODE] == `FWS_MODE_TOGGLE) ?
              !toggling : polled_done) begin
            // array data only from a fresh read after completion
            st_q <= S_DATA; // [R10]
          end else if (cur_q[5] && recheck_q) begin
            fail_q <= 1'b1; // [R20]
            O_DATA_BUS_WORD <= `FWS_RESET_CMD; // [R21]
            st_q <= S_RST;
          end else begin
            // timeout flag seen: status must be read once more
            recheck_q <= cur_q[5]; // [R19]
            first_q <= cur_q;
            st_q <= S_RD2;
          end
        end
        S_DATA: begin
          if (cyc_end) begin
            rdata_q <= cur_q;
            done_q <= 1'b1;
            busy_q <= 1'b0;
            st_q <= S_IDLE;
          end
        end
        S_RST: begin
          if (cyc_end) begin
            busy_q <= 1'b0;
            done_q <= 1'b1;
            st_q <= S_IDLE;
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end
endmodule // fws_host

// ===== verif/fws_host_asserts.sv
// port assertions for the flash status host
`timescale 1ns/1ns
module fws_host_asserts (
  input wire I_MCLK,
  input wire I_RSTN,
  input wire O_HREADYOUT,
  input wire O_HRESP,
  input wire [15:0] O_DATA_BUS_WORD,
  input wire O_DATA_BUS_OE,
  input wire [15:0] O_FLASH_ADDR,
  input wire O_FLASH_CHIP_SELECT_N,
  input wire O_OUTPUT_ENABLE_N,
  input wire O_WRITE_STROBE_N
);
  default clocking @(posedge I_MCLK); endclocking
  default disable iff (!I_RSTN);
  a_bus_okay: assert property (O_HREADYOUT && !O_HRESP)
    else $error("bus slave stalled or errored");
  a_read_pulse: assert property ($fell(O_OUTPUT_ENABLE_N) |=>
    !O_OUTPUT_ENABLE_N ##1 O_OUTPUT_ENABLE_N)
    else $error("read strobe not two cycles");
  a_read_gap: assert property ($rose(O_OUTPUT_ENABLE_N) |->
    O_OUTPUT_ENABLE_N [*2]) else $error("reads too close");
  a_read_selected: assert property (!O_OUTPUT_ENABLE_N |->
    !O_FLASH_CHIP_SELECT_N) else $error("read without select");
  a_no_contention: assert property (O_DATA_BUS_OE |->
    O_OUTPUT_ENABLE_N) else $error("drive during read");
  a_reset_word: assert property (!O_WRITE_STROBE_N |->
    O_DATA_BUS_OE && O_DATA_BUS_WORD == 16'h00f0)
    else $error("write is not the reset command");
  a_write_pulse: assert property ($fell(O_WRITE_STROBE_N) |=>
    !O_WRITE_STROBE_N ##1 O_WRITE_STROBE_N)
    else $error("write strobe not two cycles");
  a_addr_steady: assert property (!O_OUTPUT_ENABLE_N &&
    !$past(O_OUTPUT_ENABLE_N) |-> $stable(O_FLASH_ADDR))
    else $error("address moved during read");
endmodule // fws_host_asserts
bind fws_host fws_host_asserts u_chk (.I_MCLK(I_MCLK), .I_RSTN(I_RSTN),
  .O_HREADYOUT(O_HREADYOUT), .O_HRESP(O_HRESP),
  .O_DATA_BUS_WORD(O_DATA_BUS_WORD), .O_DATA_BUS_OE(O_DATA_BUS_OE),
  .O_FLASH_ADDR(O_FLASH_ADDR), .O_FLASH_CHIP_SELECT_N(O_FLASH_CHIP_SELECT_N),
  .O_OUTPUT_ENABLE_N(O_OUTPUT_ENABLE_N),
  .O_WRITE_STROBE_N(O_WRITE_STROBE_N));

// ===== verif/fws_flash_model.sv
// behavioural flash status model
`timescale 1ns/1ns
module fws_flash_model (
  input wire i_cs_n,
  input wire i_oe_n,
  input wire i_we_n,
  input wire [15:0] i_wdata,
  input wire i_wdata_oe,
  output wire [15:0] o_dq,
  output wire o_ready_busy_n
);
  reg [15:0] word = 16'h0000;
  reg [15:0] mem = 16'h0000;
  reg [15:0] last = 16'h0000;
  reg tog = 1'b0;
  reg tog2 = 1'b0;
  reg ers = 1'b0;
  reg fail_q = 1'b0;
  reg fresh = 1'b0;
  integer left = 0;
  integer n_resets = 0;
  wire rd = !i_cs_n && !i_oe_n;
  wire poll = ers ? 1'b0 : ~word[7];
  wire sect = ers ? tog2 : word[2];
  // status: poll bit 7, toggle bit 6, timeout bit 5, sector toggle bit 2
  wire [15:0] stat = {word[15:8], poll, tog, fail_q, word[4:3], sect,
    word[1:0]};
  // completion read may carry an inverted upper byte
  wire [15:0] val = left > 0 ? stat :
    fresh ? {~mem[15:8], mem[7:0]} : mem;
  // released bus shows the inverse, not a kept value
  assign o_dq = rd ? val : ~last;
  assign o_ready_busy_n = (left == 0);
  // read count stands in for operation time; status live from start
  task start(input integer n, input [15:0] w, input f, input e, input p);
    left = n;
    word = w;
    fail_q = f;
    ers = e;
    // protected target: status for a while, array left untouched
    if (!p) mem = w;
    fresh = 1'b1;
  endtask
  always @(negedge rd) begin
    last = val;
    if (left == 0) fresh = 1'b0;
    else begin
      tog = ~tog;
      if (ers) tog2 = ~tog2;
      if (!fail_q) left = left - 1;
    end
  end
  always @(posedge i_we_n) begin
    if (i_wdata_oe && i_wdata == 16'h00f0) begin
      left = 0;
      fail_q = 1'b0;
      n_resets = n_resets + 1;
    end
  end
endmodule // fws_flash_model

// ===== verif/testbench.sv
// self-checking bench for the flash status host
`timescale 1ns/1ns
`include "fws_defines.vh"
module testbench;
  reg clk = 1'b0;
  reg rstn = 1'b0;
  reg [7:0] haddr = 8'h00;
  reg [1:0] htrans = 2'b00;
  reg hwrite = 1'b0;
  reg [31:0] hwdata = 32'h0;
  reg [31:0] rd;
  reg ce = 1'b1;
  reg [17:0] snap;
  wire [31:0] hrdata;
  wire [15:0] dq_in, dq_out, dq_fl, faddr;
  wire hready, hresp, dq_oe, cs_n, oe_n, we_n, rb_n;
  integer n_errors = 0;
  integer n_compared = 0;
  integer nres = 0;
  initial forever #50 clk = ~clk;
  assign dq_in = dq_oe ? dq_out : dq_fl;
  fws_host dut (.I_MCLK(clk), .I_RSTN(rstn), .I_CE(ce), .I_HSEL(1'b1),
    .I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite),
    .I_HSIZE(3'b010), .I_HREADY(hready), .I_HWDATA(hwdata),
    .O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(hresp),
    .I_DATA_BUS_WORD(dq_in), .I_READY_BUSY_N(rb_n),
    .O_DATA_BUS_WORD(dq_out), .O_DATA_BUS_OE(dq_oe), .O_FLASH_ADDR(faddr),
    .O_FLASH_CHIP_SELECT_N(cs_n), .O_OUTPUT_ENABLE_N(oe_n),
    .O_WRITE_STROBE_N(we_n));
  fws_flash_model flash (.i_cs_n(cs_n), .i_oe_n(oe_n), .i_we_n(we_n),
    .i_wdata(dq_out), .i_wdata_oe(dq_oe), .o_dq(dq_fl),
    .o_ready_busy_n(rb_n));
  task check(input [31:0] seen, input [31:0] exp);
    n_compared = n_compared + 1;
    if (seen !== exp) begin
      n_errors = n_errors + 1;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task xfer(input w, input [7:0] a, input [31:0] wd);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    @(posedge clk);
    while (!hready) @(posedge clk);
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge clk);
    while (!hready) @(posedge clk);
    rd = hrdata;
    check({31'h0, hresp}, 32'h0);
  endtask
  // flags: timeout, erase, protected, toggle mode, freeze
  task op(input integer n, input [15:0] w, input [4:0] fl,
    input [15:0] a, input [15:0] exp);
    flash.start(n, w, fl[4], fl[3], fl[2]);
    xfer(1, `FWS_OFS_ADDR, {16'h0, a});
    xfer(1, `FWS_OFS_DATA, {16'h0, w});
    xfer(1, `FWS_OFS_CTRL, {30'h0, fl[1], 1'b1});
    if (fl[0]) begin
      // clock enable low must hold chip select, output enable and the address
      ce <= 1'b0;
      @(posedge clk);
      snap = {cs_n, oe_n, faddr};
      repeat (8) begin
        @(posedge clk);
        check({14'h0, cs_n, oe_n, faddr}, {14'h0, snap});
      end
      ce <= 1'b1;
    end
    xfer(0, `FWS_OFS_STAT, 0);
    check(rd & 32'h9, 32'h1);
    while (rd[0]) xfer(0, `FWS_OFS_STAT, 0);
    check(rd & 32'hc, {28'h0, 1'b1, fl[4], 2'b0});
    check({16'h0, faddr}, {16'h0, a});
    if (fl[4]) nres = nres + 1;
    check(flash.n_resets, nres);
    if (!fl[4]) begin
      xfer(0, `FWS_OFS_RDATA, 0);
      check(rd, {16'h0, exp});
    end
  endtask
  task results;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #2000000;
    n_errors = n_errors + 1;
    results;
  end
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    xfer(0, `FWS_OFS_STAT, 0);
    check(rd, 32'h8);
    xfer(0, 8'h20, 0);
    check(rd, 32'h0);
    // program poll/toggle, protected erase and program, erase, timeouts
    op(3, 16'hc3a5, 5'b00001, 16'h0100, 16'hc3a5);
    op(4, 16'h3c5a, 5'b00010, 16'h0101, 16'h3c5a);
    op(2, 16'hffff, 5'b01110, 16'h0102, 16'h3c5a);
    op(2, 16'hc3a5, 5'b00110, 16'h0103, 16'h3c5a);
    op(3, 16'hffff, 5'b01000, 16'h0104, 16'hffff);
    op(5, 16'h3c5a, 5'b10000, 16'h0105, 16'h0000);
    op(6, 16'hc3a5, 5'b10010, 16'h0106, 16'h0000);
    // reset command on software request
    xfer(1, `FWS_OFS_CTRL, 32'h4);
    xfer(0, `FWS_OFS_STAT, 0);
    while (rd[0]) xfer(0, `FWS_OFS_STAT, 0);
    check(rd & 32'hb, 32'ha);
    check(flash.n_resets, nres + 1);
    results;
  end
endmodule // testbench
